/* File: hw/irq_thermal_pkg.sv */
// Register map, field positions and constants of the interrupt and thermal control block
package irq_thermal_pkg;
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 8;
   localparam int          LVL_W          = 6;
   localparam int          NUM_SRC        = 10;
   // Register offsets
   localparam logic [7:0]  ADDR_IRQ_CTRL  = 8'h8C;
   localparam logic [7:0]  ADDR_EN_LOW    = 8'h8D;
   localparam logic [7:0]  ADDR_EN_HIGH   = 8'h8E;
   localparam logic [7:0]  ADDR_FLAGS_LOW = 8'h8F;
   localparam logic [7:0]  ADDR_FLAGS_HI  = 8'h90;
   localparam logic [7:0]  ADDR_THERMAL   = 8'h92;
   // Interrupt control fields
   localparam int          CTRL_CLR_BIT   = 3;
   localparam int          DRIFT_MSB      = 2;
   localparam logic [2:0]  DRIFT_RST      = 3'h7;
   localparam logic [2:0]  DRIFT_MAX_CODE = 3'h4;
   localparam logic [3:0]  DRIFT_MIRROR   = 4'h9;
   // Second enable and flag register layout
   localparam int          HI_SRC8_BIT    = 5;
   localparam int          HI_SRC9_BIT    = 6;
   localparam logic [7:0]  EN_RST         = 8'h00;
   // Source indices
   localparam int          SRC_DCLK       = 0;
   localparam int          SRC_CLKMON     = 1;
   localparam int          SRC_ALIGN      = 2;
   localparam int          SRC_CLIP       = 3;
   localparam int          SRC_TALARM     = 4;
   localparam int          SRC_MDS_RISE   = 5;
   localparam int          SRC_MDS_FALL   = 6;
   localparam int          SRC_LINK_IRQ   = 7;
   localparam int          SRC_MUTE       = 8;
   localparam int          SRC_ERR_RPT    = 9;
   // Thermal control fields
   localparam int          TH_PON_BIT     = 7;
   localparam int          TH_CLR_ALM_BIT = 6;
   localparam int          TH_WIDE_BIT    = 5;
   localparam int          TH_EDGE_BIT    = 4;
   localparam int          TH_CLR_MAX_BIT = 3;
   localparam int          TH_CLR_MIN_BIT = 2;
   localparam int          TH_MODE_MSB    = 1;
   localparam logic [7:0]  TH_RST         = 8'h00;
   localparam logic [5:0]  SWEEP_NARROW   = 6'h16;
   localparam logic [5:0]  SWEEP_FULL_LO  = 6'h00;
   localparam logic [5:0]  SWEEP_TOP      = 6'h3F;
   typedef enum logic [1:0] {
      MODE_RAW     = 2'b00,
      MODE_ONESHOT = 2'b01,
      MODE_CONT    = 2'b10,
      MODE_HOLD    = 2'b11
   } th_mode_e;
   typedef enum logic [2:0] {
      MS_IDLE = 3'b001,
      MS_WAIT = 3'b010,
      MS_RUN  = 3'b100
   } meas_state_e;
endpackage

/* File: hw/edge_flag_latch.sv */
// Per-source rising-edge detectors feeding sticky enabled flags
module edge_flag_latch #(
   parameter int WIDTH = 9
) (
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_src,
   input  wire logic [WIDTH-1:0] i_en,
   input  wire logic             i_clr,
   output logic      [WIDTH-1:0] o_set,
   output logic      [WIDTH-1:0] o_flag
);
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] flag_r;
   logic [WIDTH-1:0] flag_nxt;

   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      // Set wins over a clear in the same cycle
      assign o_set[g]    = i_en[g] & i_src[g] & ~prev_r[g];
      assign flag_nxt[g] = o_set[g] | (flag_r[g] & ~i_clr);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         // Ones avoid a false edge for sources already high
         prev_r <= '1;
         flag_r <= '0;
      end else begin
         prev_r <= i_src;
         flag_r <= flag_nxt;
      end
   end

   assign o_flag = flag_r;
endmodule

/* File: hw/irq_and_thermal_alarm_ctrl.sv */
// Interrupt flag collection and thermal sensor control register block
module irq_and_thermal_alarm_ctrl
   import irq_thermal_pkg::*;
#(
   parameter int FILL_W = 4
) (
   input  wire logic                                i_clk,
   input  wire logic                                i_srst,
   input  wire logic                                i_reg_wr,
   input  wire logic                                i_reg_rd,
   input  wire logic [irq_thermal_pkg::ADDR_W-1:0]  i_reg_addr,
   input  wire logic [irq_thermal_pkg::DATA_W-1:0]  i_reg_wdata,
   output logic      [irq_thermal_pkg::DATA_W-1:0]  o_reg_rdata,
   input  wire logic                                i_dclk_mon_err,
   input  wire logic [FILL_W-1:0]                   i_elastic_fill,
   input  wire logic                                i_clk_mon,
   input  wire logic                                i_clk_align_err,
   input  wire logic                                i_clip_a,
   input  wire logic                                i_clip_b,
   input  wire logic                                i_multi_device_sync_busy_flag,
   input  wire logic                                i_link_irq,
   input  wire logic                                i_link_err_report,
   input  wire logic                                i_mute_alarm,
   input  wire logic                                i_meas_done,
   input  wire logic                                i_meas_over,
   output logic                                     o_irq,
   output logic                                     o_thermal_power_on,
   output logic                                     o_thermal_wide_sweep,
   output logic      [irq_thermal_pkg::LVL_W-1:0]   o_sweep_low,
   output logic      [irq_thermal_pkg::LVL_W-1:0]   o_sweep_high,
   output logic                                     o_edge_falling,
   output logic                                     o_raw_mode,
   output logic                                     o_meas_start,
   output logic                                     o_meas_continuous,
   output logic                                     o_thermal_alarm,
   output logic                                     o_peak_clear,
   output logic                                     o_floor_clear
);
   import irq_thermal_pkg::*;
   localparam int EDGE_W = NUM_SRC - 1;
   // Register file state
   logic [2:0]         drift_r,   drift_nxt;
   logic [7:0]         en_low_r,  en_low_nxt;
   logic [7:0]         en_high_r, en_high_nxt;
   logic [7:0]         th_r,      th_nxt;
   logic               peak_clr_r, peak_clr_nxt;
   logic               floor_clr_r, floor_clr_nxt;
   logic [7:0]         rdata_r,   rdata_nxt;
   logic               wr_ctrl, wr_th, irq_clr, alarm_clr;

   assign wr_ctrl   = i_reg_wr && (i_reg_addr == ADDR_IRQ_CTRL);
   assign wr_th     = i_reg_wr && (i_reg_addr == ADDR_THERMAL);
   assign irq_clr   = wr_ctrl && i_reg_wdata[CTRL_CLR_BIT];
   assign alarm_clr = wr_th && i_reg_wdata[TH_CLR_ALM_BIT];

   // Source conditioning
   logic               drift_hit;
   logic [EDGE_W-1:0]  edge_src, edge_en, edge_set, edge_flag;
   logic               link_flag_r, link_flag_nxt;
   logic [NUM_SRC-1:0] flags, en_all;
   logic               irq_r, irq_nxt;
   logic               alarm_r, alarm_nxt;

   always_comb begin
      drift_hit = 1'b0;
      if (drift_r <= DRIFT_MAX_CODE) begin
         drift_hit = (i_elastic_fill == FILL_W'(drift_r + 3'h1))
                  || (i_elastic_fill == FILL_W'(DRIFT_MIRROR - {1'b0, drift_r}));
      end
   end

   // Edge source order: 0..6 low flags, then 8 and 9 at slots 7 and 8
   always_comb begin
      edge_src[SRC_DCLK]     = i_dclk_mon_err | drift_hit;
      edge_src[SRC_CLKMON]   = i_clk_mon;
      edge_src[SRC_ALIGN]    = i_clk_align_err;
      edge_src[SRC_CLIP]     = i_clip_a | i_clip_b;
      edge_src[SRC_TALARM]   = alarm_r;
      edge_src[SRC_MDS_RISE] = i_multi_device_sync_busy_flag;
      edge_src[SRC_MDS_FALL] = ~i_multi_device_sync_busy_flag;
      // mute alarm and link error report
      edge_src[SRC_MUTE-1]   = i_mute_alarm;
      edge_src[SRC_ERR_RPT-1] = i_link_err_report;
      edge_en[SRC_LINK_IRQ-1:0] = en_low_r[SRC_LINK_IRQ-1:0];
      edge_en[SRC_MUTE-1]    = en_high_r[HI_SRC8_BIT];
      edge_en[SRC_ERR_RPT-1] = en_high_r[HI_SRC9_BIT];
   end

   edge_flag_latch #(
      .WIDTH (EDGE_W)
   ) u_edges (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_src  (edge_src),
      .i_en   (edge_en),
      .i_clr  (irq_clr),
      .o_set  (edge_set),
      .o_flag (edge_flag)
   );
   always_comb begin
      // level mirror, not latched; clear drops it for one cycle
      link_flag_nxt = en_low_r[SRC_LINK_IRQ] & i_link_irq & ~irq_clr;
      flags  = {edge_flag[SRC_ERR_RPT-1], edge_flag[SRC_MUTE-1], link_flag_r,
                edge_flag[SRC_LINK_IRQ-1:0]};
      en_all = {en_high_r[HI_SRC9_BIT], en_high_r[HI_SRC8_BIT], en_low_r};
      // output follows any flag; clear drops it
      irq_nxt = (|edge_set) | link_flag_nxt | ((|edge_flag) & ~irq_clr);
   end
   always_comb begin
      alarm_nxt = alarm_r;
      // clear first, a result in the same cycle wins
      if (alarm_clr) begin
         alarm_nxt = 1'b0;
      end
      if (th_r[TH_PON_BIT] && i_meas_done && (th_r[TH_MODE_MSB:0] != MODE_RAW)) begin
         // hold mode keeps a set alarm
         if (th_mode_e'(th_r[TH_MODE_MSB:0]) == MODE_HOLD) begin
            alarm_nxt = alarm_nxt | i_meas_over;
         end else begin
            alarm_nxt = i_meas_over;
         end
      end
   end

   // Register writes and reads
   always_comb begin
      drift_nxt     = drift_r;
      en_low_nxt    = en_low_r;
      en_high_nxt   = en_high_r;
      th_nxt        = th_r;
      rdata_nxt     = rdata_r;
      peak_clr_nxt  = wr_th && i_reg_wdata[TH_CLR_MAX_BIT];
      floor_clr_nxt = wr_th && i_reg_wdata[TH_CLR_MIN_BIT];
      if (wr_ctrl) begin
         drift_nxt = i_reg_wdata[DRIFT_MSB:0];
      end
      if (i_reg_wr && (i_reg_addr == ADDR_EN_LOW)) begin
         en_low_nxt = i_reg_wdata;
      end
      if (i_reg_wr && (i_reg_addr == ADDR_EN_HIGH)) begin
         en_high_nxt = '0;
         en_high_nxt[HI_SRC9_BIT:HI_SRC8_BIT] = i_reg_wdata[HI_SRC9_BIT:HI_SRC8_BIT];
      end
      if (wr_th) begin
         th_nxt = i_reg_wdata;
         th_nxt[TH_CLR_ALM_BIT] = 1'b0;
         th_nxt[TH_CLR_MAX_BIT] = 1'b0;
         th_nxt[TH_CLR_MIN_BIT] = 1'b0;
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            ADDR_IRQ_CTRL:  rdata_nxt = {5'h00, drift_r};
            ADDR_EN_LOW:    rdata_nxt = en_low_r;
            ADDR_EN_HIGH:   rdata_nxt = en_high_r;
            ADDR_FLAGS_LOW: rdata_nxt = flags[7:0];
            ADDR_FLAGS_HI:  rdata_nxt = {1'b0, flags[SRC_ERR_RPT], flags[SRC_MUTE], 5'h00};
            ADDR_THERMAL:   rdata_nxt = th_r;
            default:        rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         drift_r     <= DRIFT_RST;
         en_low_r    <= EN_RST;
         en_high_r   <= EN_RST;
         th_r        <= TH_RST;
         peak_clr_r  <= 1'b0;
         floor_clr_r <= 1'b0;
         rdata_r     <= 8'h00;
         link_flag_r <= 1'b0;
         irq_r       <= 1'b0;
         alarm_r     <= 1'b0;
      end else begin
         drift_r     <= drift_nxt;
         en_low_r    <= en_low_nxt;
         en_high_r   <= en_high_nxt;
         th_r        <= th_nxt;
         peak_clr_r  <= peak_clr_nxt;
         floor_clr_r <= floor_clr_nxt;
         rdata_r     <= rdata_nxt;
         link_flag_r <= link_flag_nxt;
         irq_r       <= irq_nxt;
         alarm_r     <= alarm_nxt;
      end
   end

   // Measurement sequencer
   meas_state_e ms_r, ms_nxt;
   logic        start_r, start_nxt;
   th_mode_e    mode;
   logic        powered;

   assign mode    = th_mode_e'(th_r[TH_MODE_MSB:0]);
   assign powered = th_r[TH_PON_BIT];

   // mode selects raw, one-shot or repeated
   always_comb begin
      ms_nxt    = ms_r;
      start_nxt = 1'b0;
      unique case (ms_r)
         MS_IDLE: begin
            if (powered && wr_th && (i_reg_wdata[TH_MODE_MSB:0] == MODE_ONESHOT)) begin
               ms_nxt    = MS_WAIT;
               start_nxt = 1'b1;
            end else if (powered && (mode == MODE_CONT || mode == MODE_HOLD)) begin
               ms_nxt    = MS_RUN;
               start_nxt = 1'b1;
            end
         end
         MS_WAIT: begin
            if (!powered || i_meas_done) begin
               ms_nxt = MS_IDLE;
            end
         end
         MS_RUN: begin
            if (!powered || mode == MODE_RAW || mode == MODE_ONESHOT) begin
               ms_nxt = MS_IDLE;
            end else if (i_meas_done) begin
               start_nxt = 1'b1;
            end
         end
         default: begin
            ms_nxt = MS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ms_r    <= MS_IDLE;
         start_r <= 1'b0;
      end else begin
         ms_r    <= ms_nxt;
         start_r <= start_nxt;
      end
   end

   // Outputs
   assign o_reg_rdata          = rdata_r;
   assign o_irq                = irq_r;
   assign o_thermal_power_on   = th_r[TH_PON_BIT];
   assign o_thermal_wide_sweep = th_r[TH_WIDE_BIT];
   assign o_sweep_low          = th_r[TH_WIDE_BIT] ? SWEEP_FULL_LO : SWEEP_NARROW;
   assign o_sweep_high         = SWEEP_TOP;
   assign o_edge_falling       = th_r[TH_EDGE_BIT];
   assign o_raw_mode           = powered && (mode == MODE_RAW);
   assign o_meas_start         = start_r;
   assign o_meas_continuous    = (ms_r == MS_RUN);
   assign o_thermal_alarm      = alarm_r;
   assign o_peak_clear         = peak_clr_r;
   assign o_floor_clear        = floor_clr_r;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_clear_all: assert property (
      (irq_clr && edge_set == '0 && !link_flag_nxt) |=> (flags == '0 && !o_irq))
      else $error("flags survived clear");
   a_drift_off: assert property (
      (drift_r > DRIFT_MAX_CODE) |-> !drift_hit)
      else $error("drift fired while disabled");
   a_enable_gate: assert property (
      1'b1 |=> ((flags & ~$past(flags) & ~$past(en_all)) == '0))
      else $error("disabled source set flag");
   a_high_enables: assert property (
      (i_reg_wr && i_reg_addr == ADDR_EN_HIGH) |=> (en_high_r[4:0] == 5'h00 && !en_high_r[7]))
      else $error("reserved enable bits stored");
   a_busy_fall: assert property (
      ($fell(i_multi_device_sync_busy_flag) && en_low_r[SRC_MDS_FALL]) |=> flags[SRC_MDS_FALL])
      else $error("busy fall missed");
   a_alarm_edge: assert property (
      ($rose(alarm_r) && en_low_r[SRC_TALARM]) |=> flags[SRC_TALARM])
      else $error("alarm edge missed");
   a_clip_or: assert property (
      ($rose(i_clip_a | i_clip_b) && en_low_r[SRC_CLIP]) |=> flags[SRC_CLIP])
      else $error("clip edge missed");
   a_err_rpt: assert property (
      ($rose(i_link_err_report) && en_high_r[HI_SRC9_BIT]) |=> flags[SRC_ERR_RPT])
      else $error("error report edge missed");
   a_hold_alarm: assert property (
      (mode == MODE_HOLD && alarm_r && !alarm_clr) |=> alarm_r)
      else $error("held alarm dropped");
   a_alarm_clear: assert property (
      (alarm_clr && !(i_meas_done && i_meas_over)) |=> !alarm_r)
      else $error("alarm not cleared");
   a_peak_pulse: assert property (
      (wr_th && i_reg_wdata[TH_CLR_MAX_BIT]) |=> o_peak_clear ##1 !o_peak_clear[*1])
      else $error("peak clear not one pulse");
   a_irq_level: assert property (
      (|flags) |-> o_irq)
      else $error("flag set without interrupt");

   c_irq_up:    cover property ($rose(o_irq));
   c_cleared:   cover property (o_irq ##1 irq_clr ##1 !o_irq);
   c_one_shot:  cover property (ms_r == MS_WAIT ##[1:20] ms_r == MS_IDLE);
   c_busy_fall: cover property ($fell(i_multi_device_sync_busy_flag) ##1 flags[SRC_MDS_FALL]);
endmodule

/* File: tb/testbench.sv */
// Self-checking testbench for the interrupt flag and thermal control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_thermal_pkg::*;
   logic       i_clk = 0, i_srst = 1, i_reg_wr = 0, i_reg_rd = 0;
   logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
   logic [3:0] i_elastic_fill = 0;
   logic       i_dclk_mon_err = 0, i_clk_mon = 0, i_clk_align_err = 0, i_clip_a = 0;
   logic       i_clip_b = 0, i_multi_device_sync_busy_flag = 0, i_link_irq = 0;
   logic       i_link_err_report = 0, i_mute_alarm = 0, i_meas_done = 0, i_meas_over = 0;
   logic       o_irq, o_thermal_power_on, o_thermal_wide_sweep, o_edge_falling, o_raw_mode;
   logic       o_meas_start, o_meas_continuous, o_thermal_alarm, o_peak_clear, o_floor_clear;
   logic [5:0] o_sweep_low, o_sweep_high;
   logic [7:0] en_lo, en_hi, rv;
   logic [15:0] e;
   logic       pick;
   int         n_fail = 0, compares = 0, seed = 8;
   int         n_start = 0, n_peak = 0, n_floor = 0, s, s2;
   int         srcs[8] = '{0, 1, 2, 3, 5, 7, 8, 9};

   irq_and_thermal_alarm_ctrl #(.FILL_W(4)) dut (
      .i_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
      .i_dclk_mon_err, .i_elastic_fill, .i_clk_mon, .i_clk_align_err, .i_clip_a,
      .i_clip_b, .i_multi_device_sync_busy_flag, .i_link_irq, .i_link_err_report,
      .i_mute_alarm, .i_meas_done, .i_meas_over, .o_irq, .o_thermal_power_on,
      .o_thermal_wide_sweep, .o_sweep_low, .o_sweep_high, .o_edge_falling, .o_raw_mode,
      .o_meas_start, .o_meas_continuous, .o_thermal_alarm, .o_peak_clear, .o_floor_clear
   );

   always #5 i_clk = ~i_clk;

   // Pulse counters, sampled mid-cycle
   always @(negedge i_clk) begin
      if (o_meas_start === 1'b1) n_start++;
      if (o_peak_clear === 1'b1) n_peak++;
      if (o_floor_clear === 1'b1) n_floor++;
   end

   task automatic summarize;
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_reg_wr = 1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_clk);
      i_reg_wr = 0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      i_reg_rd = 1;
      i_reg_addr = a;
      @(negedge i_clk);
      i_reg_rd = 0;
      chk(o_reg_rdata, exp);
   endtask

   task automatic set_src(input int k, input logic v);
      case (k)
         0: i_dclk_mon_err = v;
         1: i_clk_mon = v;
         2: i_clk_align_err = v;
         3: begin
            i_clip_a = v & pick;
            i_clip_b = v & ~pick;
         end
         5: i_multi_device_sync_busy_flag = v;
         7: i_link_irq = v;
         8: i_mute_alarm = v;
         default: i_link_err_report = v;
      endcase
   endtask

   task automatic done(input logic over);
      @(negedge i_clk);
      i_meas_done = 1;
      i_meas_over = over;
      @(negedge i_clk);
      i_meas_done = 0;
      tick(2);
   endtask

   // Flag position of a source in {flags_high, flags_low}
   function automatic logic [15:0] bitpos(input int k);
      if (k == 8) return 16'h2000;
      if (k == 9) return 16'h4000;
      return 16'h0001 << k;
   endfunction

   function automatic logic [7:0] drift_hit(input int c, input int f);
      return 8'((c <= 4) && (f == c + 1 || f == 9 - c));
   endfunction

   initial begin
      tick(10);
      i_srst = 0;
      rd(ADDR_EN_LOW, 8'h00);
      rd(ADDR_EN_HIGH, 8'h00);
      rd(ADDR_IRQ_CTRL, 8'h07);
      rd(ADDR_THERMAL, 8'h00);
      chk(8'(o_sweep_low), 8'h16);
      chk(8'(o_sweep_high), 8'h3F);
      chk(8'(o_irq), 8'h00);
      wr(8'h91, 8'($random(seed)));
      rd(8'h91, 8'h00);
      wr(ADDR_FLAGS_LOW, 8'hFF);
      rd(ADDR_FLAGS_LOW, 8'h00);
      // Edge sources and the level link interrupt under random and full enable masks
      for (int r = 0; r < 4; r++) begin
         en_lo = 8'($random(seed));
         en_hi = 8'($random(seed));
         if (r == 0) begin
            en_lo = 8'hFF;
            en_hi = 8'hFF;
         end
         wr(ADDR_EN_LOW, en_lo);
         wr(ADDR_EN_HIGH, en_hi);
         rd(ADDR_EN_HIGH, en_hi & 8'h60);
         foreach (srcs[j]) begin
            pick = 1'($random(seed));
            set_src(srcs[j], 1'b1);
            tick(2);
            e = bitpos(srcs[j]) & {en_hi & 8'h60, en_lo};
            rd(ADDR_FLAGS_LOW, e[7:0]);
            rd(ADDR_FLAGS_HI, e[15:8]);
            chk(8'(o_irq), 8'(|e));
            set_src(srcs[j], 1'b0);
            tick(2);
            if (srcs[j] == 5) e[6] = en_lo[6];
            if (srcs[j] == 7) e = 16'h0000;
            rd(ADDR_FLAGS_LOW, e[7:0]);
            wr(ADDR_IRQ_CTRL, 8'h0F);
            rd(ADDR_FLAGS_LOW, 8'h00);
            rd(ADDR_FLAGS_HI, 8'h00);
            chk(8'(o_irq), 8'h00);
         end
      end
      // Drift codes against fill positions 1 to 9
      wr(ADDR_EN_LOW, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_IRQ_CTRL, 8'h08 | 8'(c));
         rd(ADDR_IRQ_CTRL, 8'(c));
         for (int f = 1; f < 10; f++) begin
            i_elastic_fill = 4'(f);
            tick(2);
            rd(ADDR_FLAGS_LOW, drift_hit(c, f));
            i_elastic_fill = 4'h0;
            wr(ADDR_IRQ_CTRL, 8'h08 | 8'(c));
         end
      end
      // Thermal control fields with random fill
      for (int i = 0; i < 6; i++) begin
         rv = 8'($random(seed));
         rv[1:0] = 2'(i);
         rv[7] = 1'(i >> 2) | 1'(i);
         if (i == 0) rv = 8'hFF;
         s = n_peak;
         s2 = n_floor;
         wr(ADDR_THERMAL, rv);
         tick(2);
         chk(8'(o_thermal_power_on), 8'(rv[7]));
         chk(8'(o_thermal_wide_sweep), 8'(rv[5]));
         chk(8'(o_sweep_low), rv[5] ? 8'h00 : 8'h16);
         chk(8'(o_edge_falling), 8'(rv[4]));
         chk(8'(o_raw_mode), 8'(rv[7] && rv[1:0] == 2'b00));
         chk(8'(n_peak - s), 8'(rv[3]));
         chk(8'(n_floor - s2), 8'(rv[2]));
         rd(ADDR_THERMAL, rv & 8'hB3);
      end
      wr(ADDR_EN_LOW, 8'h10);
      // Power off first so a pending one-shot wait returns to idle
      wr(ADDR_THERMAL, 8'h40);
      wr(ADDR_THERMAL, 8'hC0);
      wr(ADDR_IRQ_CTRL, 8'h0F);
      s = n_start;
      wr(ADDR_THERMAL, 8'h81);
      tick(3);
      chk(8'(n_start - s), 8'h01);
      done(1'b1);
      tick(5);
      chk(8'(n_start - s), 8'h01);
      chk(8'(o_thermal_alarm), 8'h01);
      rd(ADDR_FLAGS_LOW, 8'h10);
      wr(ADDR_THERMAL, 8'h82);
      tick(3);
      chk(8'(o_meas_continuous), 8'h01);
      done(1'b0);
      chk(8'(o_thermal_alarm), 8'h00);
      chk(8'(n_start - s), 8'h03);
      wr(ADDR_THERMAL, 8'h83);
      done(1'b1);
      done(1'b0);
      chk(8'(o_thermal_alarm), 8'h01);
      wr(ADDR_THERMAL, 8'hC3);
      tick(2);
      chk(8'(o_thermal_alarm), 8'h00);
      wr(ADDR_THERMAL, 8'h02);
      done(1'b1);
      chk(8'(o_thermal_alarm), 8'h00);
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      summarize();
   end
endmodule
